// file: rtl/acg_consts.svh
// register indices, field positions, reset values and timing for the frame-sync clock block
`ifndef ACG_CONSTS_SVH
`define ACG_CONSTS_SVH
// register indices; byte address is four times the index
`define ACG_IDX_P_CFG 8'h38
`define ACG_IDX_P_LOW 8'h39
`define ACG_IDX_S_CFG 8'h3A
`define ACG_IDX_S_LOW 8'h3B
`define ACG_IDX_STATUS 8'h3C
`define ACG_IDX_CTRL 8'h40
`define ACG_IDX_IRQ_STS 8'h41
`define ACG_IDX_IRQ_MASK 8'h42
// fields of the per-port frame generator config registers
`define ACG_B_INT_SEL 7
`define ACG_B_INV 6
`define ACG_F_HIGH_MSB 5
// fields of the port mode register
`define ACG_B_P_CTRL 4
`define ACG_B_S_CTRL 3
// fields of the clock error status register
`define ACG_B_RATIO_ERR 7
`define ACG_B_SRC_ERR 4
`define ACG_B_DEM_ERR 3
`define ACG_B_PDM_ERR 2
`define ACG_B_STOP 1
// reset values
`define ACG_RST_REG 8'h00
// timing: clock-stop window and system clock rate
`define ACG_STOP_TIME_US 1000
`define ACG_CLK_FREQ_MHZ 100
`endif

// file: rtl/acg_pkg.sv
// types shared by the frame-sync clock block
package acg_pkg;
  // controller/target settings of one audio port
  typedef struct packed {
    logic ctrl;
    logic int_sel;
    logic inv;
    logic [13:0] ratio;
  } acg_port_cfg_t;
  // clock fault conditions reported by neighbouring logic
  typedef struct packed {
    logic src_unsupported;
    logic custom_mn;
    logic dem_invalid;
    logic pdm_invalid;
  } acg_fault_in_t;
  // register bus slave states
  typedef enum logic [0:0] {ACG_IDLE, ACG_ACCESS} acg_bus_state_t;
endpackage : acg_pkg

// file: rtl/acg_controller.sv
// frame-sync generation, ratio checking and clock error status for both audio ports
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
`include "acg_consts.svh"

// one audio port: pin sampling, frame generator and ratio checker
module acg_port (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // settings
  input wire acg_pkg::acg_port_cfg_t cfg,
  // pins and internal clock
  input wire logic bitclk_pin,
  input wire logic fsync_pin_in,
  input wire logic internal_bitclk,
  // results
  output logic fsync_out,
  output logic fsync_oe,
  output logic ratio_err,
  output logic bitclk_edge
);
  logic [2:0] bclk_sync; // three-stage sampler of the bit clock pin
  logic [2:0] fs_sync; // three-stage sampler of the frame sync pin
  logic bclk_lvl; // accepted bit clock level
  logic fs_lvl; // accepted frame sync level
  logic int_lvl; // previous internal bit clock level
  logic [13:0] gen_cnt; // bit clocks into the current generated frame
  logic [13:0] meas_cnt; // bit clocks seen since last external frame
  logic meas_valid; // a frame start has been seen, so the count spans a whole frame
  logic [2:0] next_bclk_sync, next_fs_sync;
  logic next_bclk_lvl, next_fs_lvl, next_int_lvl;
  logic [13:0] next_gen_cnt, next_meas_cnt;
  logic next_meas_valid, next_fsync_out, next_fsync_oe, next_ratio_err;
  logic ext_rise, ext_fall, fs_rise, sel_rise, sel_fall, gen_edge;

  // edge finding and next-state computation
  always_comb begin
    next_bclk_sync = {bclk_sync[1:0], bitclk_pin};
    next_fs_sync = {fs_sync[1:0], fsync_pin_in};
    next_int_lvl = internal_bitclk;
    next_bclk_lvl = bclk_lvl;
    next_fs_lvl = fs_lvl;
    // a change counts once stages two and three agree
    if (bclk_sync[1] == bclk_sync[2]) begin
      next_bclk_lvl = bclk_sync[2];
    end
    if (fs_sync[1] == fs_sync[2]) begin
      next_fs_lvl = fs_sync[2];
    end
    ext_rise = next_bclk_lvl & ~bclk_lvl;
    ext_fall = ~next_bclk_lvl & bclk_lvl;
    fs_rise = next_fs_lvl & ~fs_lvl;
    bitclk_edge = ext_rise | ext_fall;
    // source choice: internal or external bit clock
    sel_rise = cfg.int_sel ? (internal_bitclk & ~int_lvl) : ext_rise;
    sel_fall = cfg.int_sel ? (~internal_bitclk & int_lvl) : ext_fall;
    // inversion only moves the framing edge, nothing else
    gen_edge = cfg.inv ? sel_fall : sel_rise;
    next_gen_cnt = gen_cnt;
    next_fsync_out = fsync_out;
    next_fsync_oe = cfg.ctrl;
    // frame generator, active only as controller with a ratio set
    if (!cfg.ctrl || cfg.ratio == 14'h0000) begin
      next_gen_cnt = 14'h0000;
      next_fsync_out = 1'b0;
    end else if (gen_edge) begin
      if (gen_cnt >= cfg.ratio - 14'h0001) begin
        next_gen_cnt = 14'h0000;
        next_fsync_out = 1'b1;
      end else begin
        next_gen_cnt = gen_cnt + 14'h0001;
        next_fsync_out = 1'b0;
      end
    end
    // ratio checker for an externally driven frame sync
    next_meas_cnt = meas_cnt;
    next_meas_valid = meas_valid;
    next_ratio_err = ratio_err;
    if (cfg.ctrl || cfg.ratio == 14'h0000) begin
      next_meas_cnt = 14'h0000;
      next_meas_valid = 1'b0;
      next_ratio_err = 1'b0;
    end else if (fs_rise) begin
      // mismatch sets, a matching frame clears
      next_ratio_err = meas_valid && (meas_cnt != cfg.ratio);
      next_meas_cnt = ext_rise ? 14'h0001 : 14'h0000;
      next_meas_valid = 1'b1;
    end else if (ext_rise && meas_cnt != 14'h3FFF) begin
      next_meas_cnt = meas_cnt + 14'h0001;
    end
  end

  // port state registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bclk_sync <= 3'h0;
      fs_sync <= 3'h0;
      bclk_lvl <= 1'b0;
      fs_lvl <= 1'b0;
      int_lvl <= 1'b0;
      gen_cnt <= 14'h0000;
      meas_cnt <= 14'h0000;
      meas_valid <= 1'b0;
      fsync_out <= 1'b0;
      fsync_oe <= 1'b0;
      ratio_err <= 1'b0;
    end else if (clk_en) begin
      bclk_sync <= next_bclk_sync;
      fs_sync <= next_fs_sync;
      bclk_lvl <= next_bclk_lvl;
      fs_lvl <= next_fs_lvl;
      int_lvl <= next_int_lvl;
      gen_cnt <= next_gen_cnt;
      meas_cnt <= next_meas_cnt;
      meas_valid <= next_meas_valid;
      fsync_out <= next_fsync_out;
      fsync_oe <= next_fsync_oe;
      ratio_err <= next_ratio_err;
    end
  end
endmodule : acg_port

// top: register file on the bus, both ports, clock error status and interrupt
module acg_controller #(
  parameter int STOP_CYCLES = `ACG_STOP_TIME_US * `ACG_CLK_FREQ_MHZ
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // primary audio port
  input wire logic primary_bitclk_in,
  input wire logic primary_internal_bitclk,
  input wire logic primary_fsync_in,
  output logic primary_fsync_out,
  output logic primary_fsync_oe,
  // secondary audio port
  input wire logic secondary_bitclk_in,
  input wire logic secondary_internal_bitclk,
  input wire logic secondary_fsync_in,
  output logic secondary_fsync_out,
  output logic secondary_fsync_oe,
  // fault conditions from neighbouring logic
  input wire acg_pkg::acg_fault_in_t fault_in,
  // interrupt
  output logic irq
);
  localparam logic [16:0] STOP_LIMIT = 17'(STOP_CYCLES); // stop window in cycles
  logic [7:0] p_cfg, p_low, s_cfg, s_low; // frame generator settings
  logic [7:0] mode; // controller/target selection per port
  logic [7:0] status; // live clock error status
  logic [7:0] irq_sts; // sticky event bits, write one to clear
  logic [7:0] irq_mask; // interrupt enables
  logic [16:0] stop_cnt; // cycles since last bit clock edge
  acg_pkg::acg_bus_state_t state;
  logic [7:0] next_p_cfg, next_p_low, next_s_cfg, next_s_low, next_mode;
  logic [7:0] next_status, next_irq_sts, next_irq_mask, rd_byte;
  logic [16:0] next_stop_cnt;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq, wr_en, hit, p_err, s_err;
  logic p_edge, s_edge;
  logic [9:0] idx;
  acg_pkg::acg_bus_state_t next_state;
  acg_pkg::acg_port_cfg_t p_port, s_port;

  // settings per port; ratio joins high six and low eight bits
  always_comb begin
    p_port = '{ctrl: mode[`ACG_B_P_CTRL], int_sel: p_cfg[`ACG_B_INT_SEL],
               inv: p_cfg[`ACG_B_INV], ratio: {p_cfg[`ACG_F_HIGH_MSB:0], p_low}};
    s_port = '{ctrl: mode[`ACG_B_S_CTRL], int_sel: s_cfg[`ACG_B_INT_SEL],
               inv: s_cfg[`ACG_B_INV], ratio: {s_cfg[`ACG_F_HIGH_MSB:0], s_low}};
  end

  // primary audio port
  acg_port u_primary (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(p_port),
    .bitclk_pin(primary_bitclk_in),
    .fsync_pin_in(primary_fsync_in),
    .internal_bitclk(primary_internal_bitclk),
    .fsync_out(primary_fsync_out),
    .fsync_oe(primary_fsync_oe),
    .ratio_err(p_err),
    .bitclk_edge(p_edge)
  );

  // secondary audio port
  acg_port u_secondary (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .cfg(s_port),
    .bitclk_pin(secondary_bitclk_in),
    .fsync_pin_in(secondary_fsync_in),
    .internal_bitclk(secondary_internal_bitclk),
    .fsync_out(secondary_fsync_out),
    .fsync_oe(secondary_fsync_oe),
    .ratio_err(s_err),
    .bitclk_edge(s_edge)
  );

  // status, stop watchdog, interrupt and bus next values
  always_comb begin
    idx = paddr[11:2];
    // clock-stop watchdog: any external bit clock edge restarts it
    next_stop_cnt = stop_cnt;
    if (p_edge || s_edge) begin
      next_stop_cnt = 17'h00000;
    end else if (stop_cnt < STOP_LIMIT) begin
      next_stop_cnt = stop_cnt + 17'h00001;
    end
    // live status; unlisted bits stay zero
    next_status = 8'h00;
    next_status[`ACG_B_RATIO_ERR] = p_err | s_err;
    next_status[`ACG_B_SRC_ERR] = fault_in.src_unsupported & ~fault_in.custom_mn;
    next_status[`ACG_B_DEM_ERR] = fault_in.dem_invalid;
    next_status[`ACG_B_PDM_ERR] = fault_in.pdm_invalid;
    next_status[`ACG_B_STOP] = (next_stop_cnt >= STOP_LIMIT);
    // read decode
    hit = 1'b1;
    case (idx)
      10'(`ACG_IDX_P_CFG): rd_byte = p_cfg;
      10'(`ACG_IDX_P_LOW): rd_byte = p_low;
      10'(`ACG_IDX_S_CFG): rd_byte = s_cfg;
      10'(`ACG_IDX_S_LOW): rd_byte = s_low;
      10'(`ACG_IDX_STATUS): rd_byte = status;
      10'(`ACG_IDX_CTRL): rd_byte = mode;
      10'(`ACG_IDX_IRQ_STS): rd_byte = irq_sts;
      10'(`ACG_IDX_IRQ_MASK): rd_byte = irq_mask;
      default: begin
        rd_byte = 8'h00;
        hit = 1'b0;
      end
    endcase
    wr_en = psel && penable && pready && pwrite && pstrb[0] && hit;
    next_p_cfg = p_cfg;
    next_p_low = p_low;
    next_s_cfg = s_cfg;
    next_s_low = s_low;
    next_mode = mode;
    next_irq_mask = irq_mask;
    next_irq_sts = irq_sts;
    // writes land only on the completing access edge
    if (wr_en) begin
      case (idx)
        10'(`ACG_IDX_P_CFG): next_p_cfg = pwdata[7:0];
        10'(`ACG_IDX_P_LOW): next_p_low = pwdata[7:0];
        10'(`ACG_IDX_S_CFG): next_s_cfg = pwdata[7:0];
        10'(`ACG_IDX_S_LOW): next_s_low = pwdata[7:0];
        10'(`ACG_IDX_CTRL): begin
          next_mode = 8'h00;
          next_mode[`ACG_B_P_CTRL] = pwdata[`ACG_B_P_CTRL];
          next_mode[`ACG_B_S_CTRL] = pwdata[`ACG_B_S_CTRL];
        end
        10'(`ACG_IDX_IRQ_STS): next_irq_sts = irq_sts & ~pwdata[7:0];
        10'(`ACG_IDX_IRQ_MASK): next_irq_mask = pwdata[7:0];
        default: next_irq_mask = irq_mask;
      endcase
    end
    // new error events set after the clear, so they win
    next_irq_sts = next_irq_sts | (next_status & ~status);
    next_irq = |(next_irq_sts & next_irq_mask);
    // bus handshake: answer in the first access cycle
    next_state = state;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    case (state)
      acg_pkg::ACG_IDLE: begin
        if (psel && !penable) begin
          next_state = acg_pkg::ACG_ACCESS;
          next_pready = 1'b1;
          next_pslverr = ~hit;
          next_prdata = {24'h000000, rd_byte};
        end
      end
      acg_pkg::ACG_ACCESS: begin
        next_state = acg_pkg::ACG_IDLE;
      end
      default: next_state = acg_pkg::ACG_IDLE;
    endcase
  end

  // register file, status and bus registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      p_cfg <= `ACG_RST_REG;
      p_low <= `ACG_RST_REG;
      s_cfg <= `ACG_RST_REG;
      s_low <= `ACG_RST_REG;
      mode <= `ACG_RST_REG;
      status <= `ACG_RST_REG;
      irq_sts <= `ACG_RST_REG;
      irq_mask <= `ACG_RST_REG;
      stop_cnt <= 17'h00000;
      irq <= 1'b0;
      state <= acg_pkg::ACG_IDLE;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      p_cfg <= next_p_cfg;
      p_low <= next_p_low;
      s_cfg <= next_s_cfg;
      s_low <= next_s_low;
      mode <= next_mode;
      status <= next_status;
      irq_sts <= next_irq_sts;
      irq_mask <= next_irq_mask;
      stop_cnt <= next_stop_cnt;
      irq <= next_irq;
      state <= next_state;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : acg_controller

// file: dv/acg_host_model.sv
// behavioural audio host driving bit clock and frame sync toward the block
`timescale 1ns/1ns
module acg_host_model (
  // control from the bench
  input wire logic run,
  input wire logic [13:0] ratio,
  // pins toward the block
  output logic bitclk,
  output logic fsync
);
  // bit clocks counted within the current frame
  int cnt;
  // 80 ns bit clock that parks low when stopped; frame sync moves on falling edges
  initial begin
    bitclk = 1'b0;
    fsync = 1'b0;
    cnt = 0;
    #13;
    forever begin
      #40;
      // finish a high phase even when asked to stop
      if (run || bitclk) begin
        bitclk = ~bitclk;
        if (!bitclk) begin
          cnt = (cnt + 1 >= int'(ratio)) ? 0 : cnt + 1;
          fsync = (cnt == 0);
        end
      end
    end
  end
endmodule : acg_host_model

// file: dv/acg_controller_props.sv
// concurrent checks on the frame-sync clock block ports
`timescale 1ns/1ns
module acg_controller_props (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // frame sync, faults, interrupt
  input wire logic primary_fsync_out,
  input wire logic primary_fsync_oe,
  input wire acg_pkg::acg_fault_in_t fault_in,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // setup phase offered in idle
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  // completed read of the status word
  sequence s_sts;
    pready && !pwrite && paddr[11:2] == 10'h03C;
  endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_sts_resv:
    assert property (s_sts |-> {prdata[31:8], prdata[6:5], prdata[0]} == 27'h0000000)
    else $error("reserved status bits set");
  a_fault_map:
    assert property (s_sts ##0 (fault_in == $past(fault_in) && fault_in == $past(fault_in, 3))
      |-> prdata[4:2] == {fault_in.src_unsupported & ~fault_in.custom_mn,
      fault_in.dem_invalid, fault_in.pdm_invalid})
    else $error("fault flags wrong");
  a_frame_oe:
    assert property ($rose(primary_fsync_out) |-> primary_fsync_oe)
    else $error("frame sync without drive");
  a_frame_gap:
    assert property ($fell(primary_fsync_out) |-> !primary_fsync_out [*2])
    else $error("frame gap too short");
  a_irq_drop:
    assert property ($fell(irq) |-> $past(pready && pwrite) || $past(pready && pwrite, 2)
      || $past(pready && pwrite, 3))
    else $error("irq dropped without a write");
endmodule : acg_controller_props
bind acg_controller acg_controller_props u_props (.ref_clk(ref_clk), .rst(rst),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_fsync_out(primary_fsync_out),
  .primary_fsync_oe(primary_fsync_oe), .fault_in(fault_in), .irq(irq));

// file: dv/testbench.sv
// self-checking bench for the frame-sync clock block
`timescale 1ns/1ns
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
  $display("wrong value %s exp %0h got %0h", n, e, g); bad_count++; end end
module testbench;
  // clock, reset, bus
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // audio side, faults, interrupt
  logic ibclk = 1'b0;
  logic [1:0] ph = 2'h0;
  logic hbclk;
  logic hfs;
  logic run = 1'b1;
  logic [13:0] hratio = 14'h0006;
  logic [1:0] fo;
  logic [1:0] fo_d = 2'h0;
  logic [1:0] oe;
  logic [3:0] fault = 4'h0;
  logic irq;
  // counters and frame periods
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int last [2] = '{0, 0};
  int per [2] = '{0, 0};
  always #5 ref_clk = ~ref_clk;
  // internal bit clock, four cycles a period
  always @(posedge ref_clk) begin
    ph <= ph + 2'h1;
    ibclk <= ph[1];
  end
  // rise-to-rise period of each frame sync
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    fo_d <= fo;
    for (int i = 0; i < 2; i++) begin
      if (fo[i] && !fo_d[i]) begin
        per[i] <= cyc - last[i];
        last[i] <= cyc;
      end
    end
  end
  acg_controller #(.STOP_CYCLES(200)) i_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .primary_bitclk_in(hbclk), .primary_internal_bitclk(ibclk), .primary_fsync_in(hfs),
    .primary_fsync_out(fo[0]), .primary_fsync_oe(oe[0]), .secondary_bitclk_in(hbclk),
    .secondary_internal_bitclk(ibclk), .secondary_fsync_in(hfs),
    .secondary_fsync_out(fo[1]), .secondary_fsync_oe(oe[1]), .fault_in(fault), .irq(irq));
  acg_host_model i_host (.run(run), .ratio(hratio), .bitclk(hbclk), .fsync(hfs));
  // one bus transfer: setup, access until pready, release
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // no fixed wait: only the hang guard ends a missing answer
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    bus(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    bus(1'b0, a, 8'h00, r, e);
    `CHK(n, x, r)
  endtask : rd
  // reset values, read-back, read-only status, dropped and refused accesses
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    for (int k = 0; k < 5; k++) rd("reset", 12'h0E0 + 12'(4 * k), 32'h0);
    wr(12'h0F0, 8'h9E);
    rd("status ro", 12'h0F0, 32'h0);
    wr(12'h0E0, 8'hFF);
    wr(12'h0E4, 8'hA5);
    wr(12'h0E8, 8'hC3);
    wr(12'h0EC, 8'h5A);
    pstrb <= 4'h0;
    wr(12'h0E4, 8'h11);
    pstrb <= 4'hF;
    rd("p cfg", 12'h0E0, 32'hFF);
    rd("p low", 12'h0E4, 32'hA5);
    rd("s cfg", 12'h0E8, 32'hC3);
    rd("s low", 12'h0EC, 32'h5A);
    for (int k = 0; k < 4; k++) wr(12'h0E0 + 12'(4 * k), 8'h00);
    bus(1'b0, 12'h1FC, 8'h00, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
  endtask : t_regs
  // fault inputs onto status bits, then a stopped audio clock
  task automatic t_status;
    for (int i = 0; i < 16; i++) begin
      fault <= 4'(i);
      repeat (3) @(posedge ref_clk);
      rd("faults", 12'h0F0, {27'h0, i[3] & ~i[2], i[1], i[0], 2'h0});
    end
    fault <= 4'h0;
    run <= 1'b0;
    repeat (150) @(posedge ref_clk);
    rd("stop early", 12'h0F0, 32'h0);
    repeat (150) @(posedge ref_clk);
    rd("stopped", 12'h0F0, 32'h2);
    run <= 1'b1;
    repeat (30) @(posedge ref_clk);
    rd("clock back", 12'h0F0, 32'h0);
    // frozen enable: 300 cycles with clk_en low and the clock stopped, then status reads zero 30 cycles after the clock returns
    run <= 1'b0;
    clk_en <= 1'b0;
    repeat (300) @(posedge ref_clk);
    clk_en <= 1'b1;
    run <= 1'b1;
    repeat (30) @(posedge ref_clk);
    rd("frozen stop", 12'h0F0, 32'h0);
  endtask : t_status
  // sticky event, masked, unmasked, cleared by writing one
  task automatic t_irq;
    wr(12'h104, 8'hFF);
    wr(12'h108, 8'h00);
    fault <= 4'h1;
    repeat (4) @(posedge ref_clk);
    `CHK("irq masked", 1'b0, irq)
    rd("irq sts", 12'h104, 32'h4);
    wr(12'h108, 8'h04);
    repeat (2) @(posedge ref_clk);
    `CHK("irq up", 1'b1, irq)
    wr(12'h104, 8'h04);
    repeat (2) @(posedge ref_clk);
    `CHK("irq down", 1'b0, irq)
    rd("irq sts clr", 12'h104, 32'h0);
    fault <= 4'h0;
  endtask : t_irq
  // target port against a host whose frame length matches, then does not
  task automatic t_ratio;
    wr(12'h0E4, 8'h06);
    repeat (200) @(posedge ref_clk);
    rd("ratio ok", 12'h0F0, 32'h0);
    hratio <= 14'h0005;
    repeat (200) @(posedge ref_clk);
    rd("ratio bad", 12'h0F0, 32'h80);
    hratio <= 14'h0006;
    repeat (200) @(posedge ref_clk);
    rd("ratio healed", 12'h0F0, 32'h0);
    wr(12'h0E4, 8'h00);
  endtask : t_ratio
  // controller frames from each clock choice and polarity, then back to target
  task automatic t_frames;
    wr(12'h100, 8'h18);
    wr(12'h0E0, 8'h81);
    wr(12'h0E4, 8'h02);
    wr(12'h0EC, 8'h05);
    repeat (2400) @(posedge ref_clk);
    `CHK("p int 258", 32'h408, per[0])
    `CHK("s ext 5", 32'h28, per[1])
    `CHK("drive", 2'h3, oe)
    wr(12'h0E0, 8'h40);
    wr(12'h0E4, 8'h09);
    wr(12'h0E8, 8'hC0);
    repeat (300) @(posedge ref_clk);
    `CHK("p ext inv 9", 32'h48, per[0])
    `CHK("s int inv 5", 32'h14, per[1])
    wr(12'h100, 8'h00);
    repeat (20) @(posedge ref_clk);
    `CHK("target", 4'h0, {fo, oe})
  endtask : t_frames
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_regs();
    t_status();
    t_irq();
    t_ratio();
    t_frames();
    test_done();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
endmodule : testbench
